//--- logic/hhp_cfg.svh
// Constants of the histogram and Hough processor: widths, reset values,
// field positions. Assumes inclusion by bare name from design files.
`ifndef HHP_CFG_SVH
`define HHP_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define HHP_PIX_W    9
`define HHP_TSEL_W   2
`define HHP_LUT_AW   11
`define HHP_CRD_W    12
`define HHP_ACC_W    24
`define HHP_ACC_AW   12
`define HHP_SYNC_W   50

// ----------------------------------------------------------------
// Values and fields
// ----------------------------------------------------------------
`define HHP_ACC_MAX  24'hFFFFFF
`define HHP_CRD_MAX  12'hFFF
`define HHP_MODE_RST 2'h0
`define HHP_TSEL_RST 2'h0
`define HHP_LOC_Y_LSB 12
`define HHP_SEL_BIT  0
`endif

//--- logic/hhp_pkg.sv
// Types shared by the processor top and its testbench.
// Assumes hhp_cfg.svh is compiled alongside.
package hhp_pkg;
  typedef enum logic [1:0] {
    MODE_HIST   = 2'h0,
    MODE_HOUGH  = 2'h1,
    MODE_LOCATE = 2'h2
  } hhp_mode_t;

  typedef enum logic [1:0] {
    TGT_ACC  = 2'h0,
    TGT_LUT  = 2'h1,
    TGT_MARK = 2'h2
  } hhp_tgt_t;

  typedef enum logic [1:0] {
    IO_IDLE  = 2'b00,
    IO_FETCH = 2'b01,
    IO_SHOW  = 2'b11
  } hhp_io_t;
endpackage

//--- logic/hhp_mem_if.sv
// Port bundle between the top and one memory: one write, one read port.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface hhp_mem_if #(parameter int W = 9, parameter int AW = 11);
  logic          we;
  logic [AW-1:0] waddr;
  logic [W-1:0]  wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0]  rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface

//--- logic/hhp_mem.sv
// Simple dual-port memory with registered read data.
// Assumes contents are cleared by host writes, not by reset.
`timescale 1ns/1ps
module hhp_mem #(
  parameter int W  = 9,
  parameter int AW = 11
) (
  input wire logic clk,
  input wire logic rst,
  hhp_mem_if.mem   bus
);
  logic [W-1:0] ram [2**AW];
  logic [W-1:0] rd_q;
  logic [W-1:0] rd_d;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = ram[bus.raddr];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Array has no reset: a clear would cost a sweep of every word
  always_ff @(posedge clk) begin
    if (bus.we) begin
      ram[bus.waddr] <= bus.wdata;
    end
  end

  assign bus.rdata = rd_q;
endmodule

//--- logic/hhp_top.sv
// Histogram, modified Hough and pixel location processor.
// Assumes pixel and host strobes arrive as slow pins sampled by clk.
`timescale 1ns/1ps
`include "hhp_cfg.svh"
module hhp_top (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   pixel_input_clock,
  input  wire logic [`HHP_PIX_W-1:0]  pixel_in,
  input  wire logic                   processing_run,
  input  wire logic                   x_counter_advance,
  input  wire logic                   x_counter_clear,
  input  wire logic                   y_counter_advance,
  input  wire logic                   y_counter_clear,
  input  wire logic [1:0]             mode_in,
  input  wire logic [`HHP_TSEL_W-1:0] table_in,
  input  wire logic                   mode_load,
  input  wire logic                   host_memory_clock,
  input  wire logic [1:0]             host_target,
  input  wire logic                   host_write,
  input  wire logic                   host_read,
  input  wire logic                   host_addr_clear,
  input  wire logic [`HHP_ACC_W-1:0]  host_data_in,
  output logic      [`HHP_ACC_W-1:0]  data_out,
  output logic                        data_valid,
  output logic                        marker_out,
  output logic      [`HHP_CRD_W-1:0]  list_count,
  output logic                        list_full,
  output logic      [`HHP_CRD_W-1:0]  x_count,
  output logic      [`HHP_CRD_W-1:0]  y_count,
  output logic                        busy
);
  localparam int PW = `HHP_PIX_W;
  localparam int TW = `HHP_TSEL_W;
  localparam int CW = `HHP_CRD_W;
  localparam int AW = `HHP_ACC_W;
  localparam int SW = `HHP_SYNC_W;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] hhp_param(
    input logic [CW-1:0] crd,
    input logic [PW-1:0] tbl
  );
    hhp_param = crd + CW'(tbl);
  endfunction

  function automatic logic [AW-1:0] hhp_sat_inc(
    input logic [AW-1:0] v
  );
    hhp_sat_inc = (v == `HHP_ACC_MAX) ? v : v + 24'h000001;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and clock edge detection
  // ----------------------------------------------------------------
  logic [SW-1:0] pins;
  logic [SW-1:0] sy1_q;
  logic [SW-1:0] sy1_d;
  logic [SW-1:0] sy2_q;
  logic [SW-1:0] sy2_d;
  logic          pclk_prev_q;
  logic          pclk_prev_d;
  logic          hclk_prev_q;
  logic          hclk_prev_d;
  logic          pclk_s;
  logic [PW-1:0] pix_s;
  logic          run_s;
  logic          xadv_s;
  logic          xclr_s;
  logic          yadv_s;
  logic          yclr_s;
  logic [1:0]    mode_s;
  logic [TW-1:0] tsel_s;
  logic          mload_s;
  logic          hclk_s;
  logic [1:0]    htgt_s;
  logic          hwr_s;
  logic          hrd_s;
  logic          hclr_s;
  logic [AW-1:0] hdat_s;
  logic          pclk_edge;
  logic          hclk_edge;

  assign pins = {pixel_input_clock, pixel_in, processing_run,
                 x_counter_advance, x_counter_clear, y_counter_advance,
                 y_counter_clear, mode_in, table_in, mode_load,
                 host_memory_clock, host_target, host_write, host_read,
                 host_addr_clear, host_data_in};

  // Data rides the same two stages as its clock, so both stay aligned
  always_comb begin
    sy1_d       = pins;
    sy2_d       = sy1_q;
    pclk_prev_d = pclk_s;
    hclk_prev_d = hclk_s;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sy1_q       <= '0;
      sy2_q       <= '0;
      pclk_prev_q <= 1'b0;
      hclk_prev_q <= 1'b0;
    end else begin
      sy1_q       <= sy1_d;
      sy2_q       <= sy2_d;
      pclk_prev_q <= pclk_prev_d;
      hclk_prev_q <= hclk_prev_d;
    end
  end

  assign {pclk_s, pix_s, run_s, xadv_s, xclr_s, yadv_s, yclr_s, mode_s,
          tsel_s, mload_s, hclk_s, htgt_s, hwr_s, hrd_s, hclr_s,
          hdat_s} = sy2_q;

  // A 20 MHz pixel clock gives at most one edge every two cycles
  assign pclk_edge = pclk_s & ~pclk_prev_q;
  assign hclk_edge = hclk_s & ~hclk_prev_q;

  // ----------------------------------------------------------------
  // Mode latches, coordinate counters, location list
  // ----------------------------------------------------------------
  hhp_pkg::hhp_mode_t mode_q;
  hhp_pkg::hhp_mode_t mode_d;
  logic [TW-1:0]      tsel_q;
  logic [TW-1:0]      tsel_d;
  logic [CW-1:0]      x_q;
  logic [CW-1:0]      x_d;
  logic [CW-1:0]      y_q;
  logic [CW-1:0]      y_d;
  logic [CW-1:0]      ptr_q;
  logic [CW-1:0]      ptr_d;
  logic               full_q;
  logic               full_d;
  logic               v2_q;
  logic               loc_wr;

  assign loc_wr = v2_q && (mode_q == hhp_pkg::MODE_LOCATE);

  always_comb begin
    mode_d = mode_q;
    tsel_d = tsel_q;
    x_d    = x_q;
    y_d    = y_q;
    ptr_d  = ptr_q;
    full_d = full_q;
    if (mload_s) begin
      mode_d = hhp_pkg::hhp_mode_t'(mode_s);
      tsel_d = tsel_s;
      ptr_d  = '0;
      full_d = 1'b0;
    end
    if (pclk_edge) begin
      if (xclr_s) begin
        x_d = '0;
      end else if (xadv_s) begin
        x_d = x_q + 12'h001;
      end
      if (yclr_s) begin
        y_d = '0;
      end else if (yadv_s) begin
        y_d = y_q + 12'h001;
      end
    end
    // A store in the same cycle as a load still counts
    if (loc_wr) begin
      if (ptr_q == `HHP_CRD_MAX) begin
        full_d = 1'b1;
      end else begin
        ptr_d = ptr_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= hhp_pkg::hhp_mode_t'(`HHP_MODE_RST);
      tsel_q <= `HHP_TSEL_RST;
      x_q    <= '0;
      y_q    <= '0;
      ptr_q  <= '0;
      full_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      tsel_q <= tsel_d;
      x_q    <= x_d;
      y_q    <= y_d;
      ptr_q  <= ptr_d;
      full_q <= full_d;
    end
  end

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  hhp_mem_if #(.W(PW), .AW(`HHP_LUT_AW)) lut_if ();
  hhp_mem_if #(.W(AW), .AW(`HHP_ACC_AW)) acc_if ();
  hhp_mem_if #(.W(1),  .AW(`HHP_ACC_AW)) mark_if ();

  // Four 512-entry tables share one array, chosen by the table select
  hhp_mem #(.W(PW), .AW(`HHP_LUT_AW)) u_lut (
    .clk (clk),
    .rst (rst),
    .bus (lut_if.mem)
  );

  hhp_mem #(.W(AW), .AW(`HHP_ACC_AW)) u_acc (
    .clk (clk),
    .rst (rst),
    .bus (acc_if.mem)
  );

  hhp_mem #(.W(1), .AW(`HHP_ACC_AW)) u_mark (
    .clk (clk),
    .rst (rst),
    .bus (mark_if.mem)
  );

  // ----------------------------------------------------------------
  // Pixel pipeline: table read, memory read, memory write
  // ----------------------------------------------------------------
  logic                pix_en;
  logic                v1_q;
  logic                v1_d;
  logic [PW-1:0]       pix1_q;
  logic [PW-1:0]       pix1_d;
  logic [CW-1:0]       x1_q;
  logic [CW-1:0]       x1_d;
  logic [CW-1:0]       y1_q;
  logic [CW-1:0]       y1_d;
  logic                v2_d;
  logic [CW-1:0]       a2_q;
  logic [CW-1:0]       a2_d;
  logic [AW-1:0]       xy2_q;
  logic [AW-1:0]       xy2_d;
  logic [`HHP_LUT_AW-1:0] lut_pa;
  logic [CW-1:0]       acc_pa;
  logic                hit;
  logic [AW-1:0]       acc_wd;

  assign pix_en = pclk_edge & run_s;

  always_comb begin
    v1_d   = pix_en;
    pix1_d = pix_s;
    x1_d   = x_q;
    y1_d   = y_q;
    if (mode_q == hhp_pkg::MODE_HOUGH) begin
      lut_pa = {tsel_q, x_q[PW-1:0]};
    end else begin
      lut_pa = {tsel_q, pix_s};
    end
    hit    = 1'b0;
    acc_pa = CW'(lut_if.rdata);
    case (mode_q)
      hhp_pkg::MODE_HIST: begin
        hit = 1'b1;
      end
      hhp_pkg::MODE_HOUGH: begin
        hit    = |pix1_q;
        acc_pa = hhp_param(y1_q, lut_if.rdata);
      end
      hhp_pkg::MODE_LOCATE: begin
        hit    = lut_if.rdata[`HHP_SEL_BIT] & ~full_q;
        acc_pa = ptr_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    v2_d  = v1_q & hit;
    a2_d  = acc_pa;
    xy2_d = {y1_q, x1_q};
    if (mode_q == hhp_pkg::MODE_LOCATE) begin
      acc_wd = xy2_q;
    end else begin
      acc_wd = hhp_sat_inc(acc_if.rdata);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      v1_q   <= 1'b0;
      pix1_q <= '0;
      x1_q   <= '0;
      y1_q   <= '0;
      v2_q   <= 1'b0;
      a2_q   <= '0;
      xy2_q  <= '0;
    end else begin
      v1_q   <= v1_d;
      pix1_q <= pix1_d;
      x1_q   <= x1_d;
      y1_q   <= y1_d;
      v2_q   <= v2_d;
      a2_q   <= a2_d;
      xy2_q  <= xy2_d;
    end
  end

  // ----------------------------------------------------------------
  // Host I/O controller
  // ----------------------------------------------------------------
  hhp_pkg::hhp_io_t  io_q;
  hhp_pkg::hhp_io_t  io_d;
  hhp_pkg::hhp_tgt_t tgt_q;
  hhp_pkg::hhp_tgt_t tgt_d;
  logic [CW-1:0]     ioa_q;
  logic [CW-1:0]     ioa_d;
  logic [AW-1:0]     out_q;
  logic [AW-1:0]     out_d;
  logic              mk_q;
  logic              mk_d;
  logic              val_q;
  logic              val_d;
  logic              host_en;
  logic              host_wr;

  // Host edges met while pixels are in flight are dropped, not queued
  assign busy    = run_s | v1_q | v2_q | (io_q != hhp_pkg::IO_IDLE);
  assign host_en = hclk_edge & ~(run_s | v1_q | v2_q);
  assign host_wr = host_en & (io_q == hhp_pkg::IO_IDLE) & ~hclr_s & hwr_s;

  always_comb begin
    io_d  = io_q;
    tgt_d = tgt_q;
    ioa_d = ioa_q;
    out_d = out_q;
    mk_d  = mk_q;
    val_d = 1'b0;
    case (io_q)
      hhp_pkg::IO_IDLE: begin
        if (host_en) begin
          tgt_d = hhp_pkg::hhp_tgt_t'(htgt_s);
          if (hclr_s) begin
            ioa_d = '0;
          end else if (hwr_s) begin
            ioa_d = ioa_q + 12'h001;
          end else if (hrd_s) begin
            io_d = hhp_pkg::IO_FETCH;
          end
        end
      end
      hhp_pkg::IO_FETCH: begin
        io_d = hhp_pkg::IO_SHOW;
      end
      hhp_pkg::IO_SHOW: begin
        case (tgt_q)
          hhp_pkg::TGT_LUT:  out_d = AW'(lut_if.rdata);
          hhp_pkg::TGT_MARK: out_d = AW'(mark_if.rdata);
          default:           out_d = acc_if.rdata;
        endcase
        mk_d  = mark_if.rdata[0];
        val_d = 1'b1;
        ioa_d = ioa_q + 12'h001;
        io_d  = hhp_pkg::IO_IDLE;
      end
      default: begin
        io_d = hhp_pkg::IO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_q  <= hhp_pkg::IO_IDLE;
      tgt_q <= hhp_pkg::TGT_ACC;
      ioa_q <= '0;
      out_q <= '0;
      mk_q  <= 1'b0;
      val_q <= 1'b0;
    end else begin
      io_q  <= io_d;
      tgt_q <= tgt_d;
      ioa_q <= ioa_d;
      out_q <= out_d;
      mk_q  <= mk_d;
      val_q <= val_d;
    end
  end

  // ----------------------------------------------------------------
  // Memory port steering
  // ----------------------------------------------------------------
  assign lut_if.raddr  = pix_en ? lut_pa : ioa_q[`HHP_LUT_AW-1:0];
  assign lut_if.we     = host_wr & (htgt_s == hhp_pkg::TGT_LUT);
  assign lut_if.waddr  = ioa_q[`HHP_LUT_AW-1:0];
  assign lut_if.wdata  = hdat_s[PW-1:0];

  assign acc_if.raddr  = v1_q ? acc_pa : ioa_q;
  assign acc_if.we     = v2_q | (host_wr & (htgt_s == hhp_pkg::TGT_ACC));
  assign acc_if.waddr  = v2_q ? a2_q : ioa_q;
  assign acc_if.wdata  = v2_q ? acc_wd : hdat_s;

  assign mark_if.raddr = ioa_q;
  assign mark_if.we    = host_wr & (htgt_s == hhp_pkg::TGT_MARK);
  assign mark_if.waddr = ioa_q;
  assign mark_if.wdata = hdat_s[0];

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out   = out_q;
  assign data_valid = val_q;
  assign marker_out = mk_q;
  assign list_count = ptr_q;
  assign list_full  = full_q;
  assign x_count    = x_q;
  assign y_count    = y_q;
endmodule

//--- dv/hhp_top_monitor.sv
// Checker of the processor top: host read timing and counter steps.
// Assumes binding onto hhp_top; it sees that module's ports only.
`timescale 1ns/1ps
`include "hhp_cfg.svh"
module hhp_top_monitor (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  pixel_input_clock,
  input wire logic                  processing_run,
  input wire logic                  x_counter_advance,
  input wire logic                  x_counter_clear,
  input wire logic                  y_counter_advance,
  input wire logic                  y_counter_clear,
  input wire logic                  host_memory_clock,
  input wire logic                  host_write,
  input wire logic                  host_read,
  input wire logic                  host_addr_clear,
  input wire logic                  data_valid,
  input wire logic [`HHP_CRD_W-1:0] list_count,
  input wire logic [`HHP_CRD_W-1:0] x_count,
  input wire logic [`HHP_CRD_W-1:0] y_count,
  input wire logic                  busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Steps
  // ----------------------------------------------------------------
  sequence pix_evt;
    $rose(pixel_input_clock);
  endsequence
  sequence rd_req;
    $rose(host_memory_clock) && host_read && !host_write &&
      !host_addr_clear && !processing_run && !busy;
  endsequence
  // Window allows for the two pin sync stages ahead of the edge
  property p_adv(adv, clr, cnt);
    logic [`HHP_CRD_W-1:0] v;
    (pix_evt ##0 (adv && !clr, v = cnt)) |-> ##[2:5] cnt == v + 12'h1;
  endproperty
  property p_clr(clr, cnt);
    (pix_evt ##0 clr) |-> ##[2:5] cnt == 12'h0;
  endproperty
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Run pin reaches busy only after its two sync stages
  AST_RUN_BUSY:
    assert property (processing_run [*3] |-> busy)
    else $error("busy low while processing runs");
  AST_VALID_PULSE:
    assert property (data_valid |=> !data_valid)
    else $error("read valid held past one cycle");
  AST_READ_ANSWER:
    assert property (rd_req |-> ##[3:8] data_valid)
    else $error("host read gave no data");
  AST_RUN_BLOCKS:
    assert property (processing_run [*8] |-> !data_valid)
    else $error("host read answered while processing");
  AST_LIST_STEP:
    assert property (!$stable(list_count) |->
      list_count == $past(list_count) + 12'h1 || list_count == 12'h0)
    else $error("list pointer jumped");
  AST_X_ADV:
    assert property (p_adv(x_counter_advance, x_counter_clear, x_count))
    else $error("x counter did not advance by one");
  AST_Y_ADV:
    assert property (p_adv(y_counter_advance, y_counter_clear, y_count))
    else $error("y counter did not advance by one");
  AST_X_CLR:
    assert property (p_clr(x_counter_clear, x_count))
    else $error("x counter not cleared");
  AST_Y_CLR:
    assert property (p_clr(y_counter_clear, y_count))
    else $error("y counter not cleared");
endmodule

bind hhp_top hhp_top_monitor i_mon (
  .clk(clk), .rst(rst), .pixel_input_clock(pixel_input_clock),
  .processing_run(processing_run), .x_counter_advance(x_counter_advance),
  .x_counter_clear(x_counter_clear), .y_counter_advance(y_counter_advance),
  .y_counter_clear(y_counter_clear), .host_memory_clock(host_memory_clock),
  .host_write(host_write), .host_read(host_read),
  .host_addr_clear(host_addr_clear), .data_valid(data_valid),
  .list_count(list_count), .x_count(x_count), .y_count(y_count),
  .busy(busy));

//--- dv/hhp_src.sv
// Model of the pixel source and the host controller on the far side.
// Assumes a free-running clk; pins change just after its rising edge.
`timescale 1ns/1ps
`include "hhp_cfg.svh"
module hhp_src (
  input wire logic                  clk,
  output logic                      pixel_input_clock,
  output logic     [`HHP_PIX_W-1:0] pixel_in,
  output logic                      host_memory_clock,
  output logic     [1:0]            host_target,
  output logic                      host_write,
  output logic                      host_read,
  output logic                      host_addr_clear,
  output logic     [`HHP_ACC_W-1:0] host_data_in
);
  initial begin
    {pixel_input_clock, host_memory_clock, host_write} = 3'h0;
    {host_read, host_addr_clear, host_target} = 4'h0;
    pixel_in     = 9'h000;
    host_data_in = 24'h000000;
  end
  // Pixel clock stands low between pixels; data inverts once released
  task automatic pix(input logic [`HHP_PIX_W-1:0] v);
    @(posedge clk);
    pixel_in          <= v;
    pixel_input_clock <= 1'b1;
    repeat (3) @(posedge clk);
    pixel_input_clock <= 1'b0;
    repeat (3) @(posedge clk);
    pixel_in          <= ~v;
  endtask
  // Host edges kept well apart so each is taken while idle
  task automatic host(input logic [1:0] t, input logic wr, rd, clr,
                      input logic [`HHP_ACC_W-1:0] d);
    @(posedge clk);
    {host_target, host_write, host_read, host_addr_clear} <= {t, wr, rd, clr};
    host_data_in      <= d;
    host_memory_clock <= 1'b1;
    repeat (3) @(posedge clk);
    host_memory_clock <= 1'b0;
    repeat (3) @(posedge clk);
    {host_write, host_read, host_addr_clear} <= 3'h0;
    host_data_in      <= ~d;
  endtask
endmodule

//--- dv/hhp_top_tb.sv
// Self-checking bench of the processor top with the source model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`include "hhp_cfg.svh"
module hhp_top_tb;
  typedef struct packed {
    logic [8:0] pix;
    logic [2:0] n;
  } hhp_row_t;
  logic                  clk, rst, processing_run, mode_load;
  logic                  x_counter_advance, x_counter_clear;
  logic                  y_counter_advance, y_counter_clear;
  logic [1:0]            mode_in, table_in, host_target;
  logic                  pixel_input_clock, host_memory_clock;
  logic                  host_write, host_read, host_addr_clear;
  logic [8:0]            pixel_in;
  logic [23:0]           host_data_in, data_out;
  logic                  data_valid, marker_out, list_full, busy;
  logic [11:0]           list_count, x_count, y_count;
  logic [24:0]           rd_q[$];
  logic [23:0]           ex [8];
  int                    miscompares, n_checks, cyc;
  // Lookup maps entry e to 7-e, so pixel p lands in bin 7-p
  hhp_row_t rows [8] = '{'{9'h000, 3'h2}, '{9'h001, 3'h0}, '{9'h002, 3'h1},
    '{9'h003, 3'h3}, '{9'h004, 3'h0}, '{9'h005, 3'h1}, '{9'h006, 3'h0},
    '{9'h007, 3'h1}};

  hhp_top i_dut (.clk(clk), .rst(rst), .pixel_input_clock(pixel_input_clock),
    .pixel_in(pixel_in), .processing_run(processing_run),
    .x_counter_advance(x_counter_advance), .x_counter_clear(x_counter_clear),
    .y_counter_advance(y_counter_advance), .y_counter_clear(y_counter_clear),
    .mode_in(mode_in), .table_in(table_in), .mode_load(mode_load),
    .host_memory_clock(host_memory_clock), .host_target(host_target),
    .host_write(host_write), .host_read(host_read),
    .host_addr_clear(host_addr_clear), .host_data_in(host_data_in),
    .data_out(data_out), .data_valid(data_valid), .marker_out(marker_out),
    .list_count(list_count), .list_full(list_full), .x_count(x_count),
    .y_count(y_count), .busy(busy));
  hhp_src i_src (.clk(clk), .pixel_input_clock(pixel_input_clock),
    .pixel_in(pixel_in), .host_memory_clock(host_memory_clock),
    .host_target(host_target), .host_write(host_write),
    .host_read(host_read), .host_addr_clear(host_addr_clear),
    .host_data_in(host_data_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (data_valid === 1'b1)
      rd_q.push_back({marker_out, data_out});
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      $display("unexpected at %0t: run too long", $time);
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [24:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen,
               exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic set_mode(input logic [1:0] m);
    mode_in   <= m;
    table_in  <= 2'h0;
    mode_load <= 1'b1;
    repeat (4) @(posedge clk);
    mode_load <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Address cleared first, then eight reads; words land in rd_q
  task automatic read_blk(input logic [1:0] t);
    int k;
    i_src.host(t, 1'b0, 1'b0, 1'b1, 24'h000000);
    for (int e = 0; e < 8; e++)
      i_src.host(t, 1'b0, 1'b1, 1'b0, 24'h000000);
    // Last valid pulse is sampled on the edge this task resumes on
    repeat (2) @(posedge clk);
    for (k = 0; k < 50 && busy !== 1'b0; k++)
      @(posedge clk);
    check(25'(rd_q.size()), 25'h0000008, "read count");
    for (int e = 0; e < 8; e++)
      check(rd_q[e], {1'(e % 2), ex[e]}, "read word");
    rd_q.delete();
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, processing_run, mode_load, mode_in, table_in} <= 7'h40;
    {x_counter_advance, x_counter_clear} <= 2'h0;
    {y_counter_advance, y_counter_clear} <= 2'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(25'(x_count), 25'h0000000, "x after reset");
    check(25'(list_count), 25'h0000000, "list after reset");
    $display("test reset done");
    for (int t = 0; t < 3; t++) begin
      i_src.host(2'(t), 1'b0, 1'b0, 1'b1, 24'h000000);
      for (int e = 0; e < 8; e++)
        i_src.host(2'(t), 1'b1, 1'b0, 1'b0, t == 1 ? 24'(7 - e) :
                   t == 2 ? 24'(e % 2) : 24'h000000);
    end
    foreach (ex[e]) ex[e] = 24'(7 - e);
    read_blk(2'(hhp_pkg::TGT_LUT));
    foreach (ex[e]) ex[e] = 24'(e % 2);
    read_blk(2'(hhp_pkg::TGT_MARK));
    $display("test table load done");
    set_mode(2'(hhp_pkg::MODE_HIST));
    processing_run <= 1'b1;
    foreach (rows[r])
      repeat (rows[r].n) i_src.pix(rows[r].pix);
    processing_run <= 1'b0;
    foreach (rows[r]) ex[7 - rows[r].pix] = 24'(rows[r].n);
    read_blk(2'(hhp_pkg::TGT_ACC));
    $display("test histogram done");
    processing_run <= 1'b1;
    i_src.host(2'(hhp_pkg::TGT_ACC), 1'b0, 1'b1, 1'b0, 24'h000000);
    repeat (10) @(posedge clk);
    check(25'(rd_q.size()), 25'h0000000, "read while running");
    processing_run <= 1'b0;
    $display("test blocked read done");
    set_mode(2'(hhp_pkg::MODE_LOCATE));
    {x_counter_clear, y_counter_clear} <= 2'h3;
    i_src.pix(9'h000);
    {x_counter_clear, y_counter_clear, x_counter_advance} <= 3'h1;
    processing_run <= 1'b1;
    for (int p = 0; p < 3; p++)
      i_src.pix(9'(p));
    {x_counter_clear, y_counter_advance} <= 2'h3;
    i_src.pix(9'h004);
    {x_counter_clear, y_counter_advance, processing_run} <= 3'h0;
    repeat (8) @(posedge clk);
    check(25'(list_count), 25'h0000003, "list count");
    check(25'(list_full), 25'h0000000, "list not full");
    check(25'(x_count), 25'h0000000, "x count");
    check(25'(y_count), 25'h0000001, "y count");
    ex[0] = 24'h000000;
    ex[1] = 24'h000002;
    ex[2] = 24'h000003;
    read_blk(2'(hhp_pkg::TGT_ACC));
    $display("test locate done");
    // Bin is y plus table[x]: zero pixel skipped, then 1+6 and 1+5
    set_mode(2'(hhp_pkg::MODE_HOUGH));
    processing_run <= 1'b1;
    i_src.pix(9'h000);
    i_src.pix(9'h005);
    i_src.pix(9'h003);
    processing_run <= 1'b0;
    check(25'(x_count), 25'h0000003, "hough x");
    ex[6] = 24'h000001;
    ex[7] = 24'h000003;
    read_blk(2'(hhp_pkg::TGT_ACC));
    $display("test hough done");
    final_report();
  end
endmodule
